//--- rtl/pca_agent.sv
`timescale 1ns/1ps
`include "pca_cfg.svh"
module pca_agent (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_go,
    input  wire logic [3:0]  i_cmd,
    input  wire logic [31:0] i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_gnt0,
    output logic             o_req0,
    output logic             o_done,
    output logic             o_abort,
    output logic [31:0]      o_rdata,
    pca_bus_if.agt           bus
);
    logic        clk_s, trdy_n, stop_n, devsel_n, gnt_n;
    logic [31:0] ad;
    pca_sync #(.W(37)) u_in (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_d({bus.clk, bus.trdy_n_i, bus.stop_n_i, bus.devsel_n_i, bus.gnt_n_i[1], bus.ad_i}),
        .o_q({clk_s, trdy_n, stop_n, devsel_n, gnt_n, ad}));
    typedef struct packed {
        logic                    clk_l, busy, done, abort, req0;
        pca_pkg::pca_ini_state_t st;
        logic [2:0]              cnt;
        logic [31:0]             ad_o, rdata;
        logic [3:0]              cbe_o, cmd;
        logic                    ad_oe, oe, frame, irdy, par, par_oe;
    } ag_t;
    ag_t a_q, a_d;
    assign bus.ad_o = a_q.ad_o;      assign bus.ad_oe = a_q.ad_oe;
    assign bus.cbe_o = a_q.cbe_o;    assign bus.cbe_oe = a_q.oe;
    assign bus.par_o = a_q.par;      assign bus.par_oe = a_q.par_oe;
    assign bus.frame_n_o = a_q.frame; assign bus.frame_oe = a_q.oe;
    assign bus.irdy_n_o = a_q.irdy;  assign bus.irdy_oe = a_q.oe;
    assign bus.trdy_n_o = 1'b1;      assign bus.trdy_oe = 1'b0;
    assign bus.stop_n_o = 1'b1;      assign bus.stop_oe = 1'b0;
    assign bus.devsel_n_o = 1'b1;    assign bus.devsel_oe = 1'b0;
    assign bus.perr_n_o = 1'b1;      assign bus.perr_oe = 1'b0;
    assign bus.serr_n_o = 1'b0;      assign bus.serr_oe = 1'b0;
    // Agent drives request line one
    assign bus.req_n_o = {2'h3, ~a_q.busy, 1'b1};
    assign bus.req_oe = 4'h2;
    assign o_req0 = a_q.req0;        assign o_done = a_q.done;
    assign o_abort = a_q.abort;      assign o_rdata = a_q.rdata;
    always_comb begin
        a_d = a_q;
        a_d.clk_l = clk_s;
        a_d.done = 1'b0;
        a_d.abort = 1'b0;
        a_d.req0 = a_q.busy;
        if (i_go && !a_q.busy) begin
            a_d.busy = 1'b1;
            a_d.cmd = i_cmd;
        end
        if (clk_s && !a_q.clk_l) begin
            a_d.par_oe = a_q.ad_oe;
            a_d.par = ^{a_q.ad_o, a_q.cbe_o};
            case (a_q.st)
                pca_pkg::PCA_IDLE: if (a_q.busy && !gnt_n && i_gnt0) begin
                    a_d.st = pca_pkg::PCA_ADDR;
                    a_d.ad_o = i_addr;
                    a_d.ad_oe = 1'b1;
                    a_d.cbe_o = a_q.cmd;
                    a_d.oe = 1'b1;
                    a_d.frame = 1'b0;
                    a_d.cnt = 3'h0;
                end
                pca_pkg::PCA_ADDR: begin
                    a_d.st = pca_pkg::PCA_DATA;
                    a_d.frame = 1'b1;
                    a_d.irdy = 1'b0;
                    a_d.cbe_o = 4'h0;
                    a_d.ad_o = i_wdata;
                    a_d.ad_oe = a_q.cmd[0];
                end
                pca_pkg::PCA_DATA: begin
                    a_d.cnt = a_q.cnt + 3'h1;
                    if (!trdy_n || !stop_n || (devsel_n && a_q.cnt == `PCA_DEVSEL_WAIT)) begin
                        a_d.done = !trdy_n;
                        a_d.abort = trdy_n;
                        a_d.rdata = ad;
                        a_d.irdy = 1'b1;
                        a_d.ad_oe = 1'b0;
                        a_d.busy = 1'b0;
                        a_d.st = pca_pkg::PCA_TURN;
                    end
                end
                pca_pkg::PCA_TURN: begin
                    a_d.oe = 1'b0;
                    a_d.st = pca_pkg::PCA_IDLE;
                end
                default: a_d.st = pca_pkg::PCA_IDLE;
            endcase
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            a_q <= '0;
            a_q.frame <= 1'b1;
            a_q.irdy <= 1'b1;
            a_q.clk_l <= 1'b1;
        end else a_q <= a_d;
    end
endmodule

//--- rtl/pca_bus_if.sv
`timescale 1ns/1ps
interface pca_bus_if;
    logic        clk;
    logic [31:0] ad_i, ad_o;
    logic        ad_oe;
    logic [3:0]  cbe_i, cbe_o;
    logic        cbe_oe;
    logic        par_i, par_o, par_oe;
    logic        frame_n_i, frame_n_o, frame_oe;
    logic        irdy_n_i, irdy_n_o, irdy_oe;
    logic        trdy_n_i, trdy_n_o, trdy_oe;
    logic        stop_n_i, stop_n_o, stop_oe;
    logic        devsel_n_i, devsel_n_o, devsel_oe;
    logic        perr_n_i, perr_n_o, perr_oe;
    logic        serr_n_i, serr_n_o, serr_oe;
    logic        idsel;
    logic [3:0]  req_n_i, req_n_o, req_oe;
    logic [3:0]  gnt_n_i, gnt_n_o, gnt_oe;
    logic        inta_n_o, inta_oe;
    modport dev (
        input  clk, ad_i, cbe_i, par_i, frame_n_i, irdy_n_i, trdy_n_i, stop_n_i,
               devsel_n_i, perr_n_i, serr_n_i, idsel, req_n_i, gnt_n_i,
        output ad_o, ad_oe, cbe_o, cbe_oe, par_o, par_oe, frame_n_o, frame_oe,
               irdy_n_o, irdy_oe, trdy_n_o, trdy_oe, stop_n_o, stop_oe,
               devsel_n_o, devsel_oe, perr_n_o, perr_oe, serr_n_o, serr_oe,
               req_n_o, req_oe, gnt_n_o, gnt_oe, inta_n_o, inta_oe
    );
    modport agt (
        input  clk, ad_i, cbe_i, par_i, frame_n_i, irdy_n_i, trdy_n_i, stop_n_i,
               devsel_n_i, perr_n_i, serr_n_i, gnt_n_i,
        output ad_o, ad_oe, cbe_o, cbe_oe, par_o, par_oe, frame_n_o, frame_oe,
               irdy_n_o, irdy_oe, trdy_n_o, trdy_oe, stop_n_o, stop_oe,
               devsel_n_o, devsel_oe, perr_n_o, perr_oe, serr_n_o, serr_oe,
               req_n_o, req_oe
    );
endinterface

//--- rtl/pca_cfg.svh
`ifndef PCA_CFG_SVH
`define PCA_CFG_SVH
`define PCA_CMD_SPECIAL   4'h1
`define PCA_CMD_IO_RD     4'h2
`define PCA_CMD_IO_WR     4'h3
`define PCA_CMD_MEM_RD    4'h6
`define PCA_CMD_MEM_WR    4'h7
`define PCA_CMD_CFG_RD    4'hA
`define PCA_CMD_CFG_WR    4'hB
`define PCA_N_REQ         4
`define PCA_DEVSEL_WAIT   3'h4
`define PCA_DIV_HALF      3'h3
`define PCA_BAR_DEFAULT   32'h8000_0000
`define PCA_BAR_MASK      32'hFFFF_0000
`endif

//--- rtl/pca_device.sv
// Functional notes
// - Arbiter on: grants for requests three..zero
// - Arbiter on: request zero is input
// - Arbiter off: drive request zero out
// - Arbiter on: drive grant zero out
// - Arbiter off: grant zero is input
// - Command in address, byte enables data
// - Even parity over AD and CBE
// - Frame spans transaction, drops last phase
// - Parity error flagged except special cycles
// - System error open-drain, also sampled
// - Claim decode; initiator checks claim
// - Config access only with IDSEL
// - Target ready completes data phase
// - Transfer needs both ready signals
// - Stop forces initiator to terminate
// - Sample on rising PCI clock edge
// - Interrupt pulls line low, open-drain
`timescale 1ns/1ps
`include "pca_cfg.svh"
module pca_device #(
    parameter logic [31:0] BAR = `PCA_BAR_DEFAULT
) (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_arb_en,
    input  wire logic        i_irq,
    input  wire logic        i_cmd_go,
    input  wire logic [3:0]  i_cmd,
    input  wire logic [31:0] i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_be,
    output logic             o_busy,
    output logic             o_done,
    output logic             o_abort,
    output logic [31:0]      o_rdata,
    output logic             o_perr_seen,
    output logic             o_serr_seen,
    output logic [31:0]      o_tgt_data,
    pca_bus_if.dev           bus
);
    logic        clk_s, clk_p;
    logic [31:0] ad;
    logic [3:0]  cbe, req_n, gnt_n;
    logic        par, frame_n, irdy_n, trdy_n, stop_n, devsel_n, perr_n, serr_n, idsel;
    pca_sync #(.W(1)) u_clk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_d(bus.clk), .o_q(clk_s));
    pca_sync #(.W(53)) u_in (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_d({bus.ad_i, bus.cbe_i, bus.req_n_i, bus.gnt_n_i, bus.par_i, bus.frame_n_i,
              bus.irdy_n_i, bus.trdy_n_i, bus.stop_n_i, bus.devsel_n_i, bus.perr_n_i,
              bus.serr_n_i, ~bus.idsel}),
        .o_q({ad, cbe, req_n, gnt_n, par, frame_n, irdy_n, trdy_n, stop_n, devsel_n,
              perr_n, serr_n, idsel}));

    typedef struct packed {
        logic                      clk_l;
        pca_pkg::pca_ini_state_t   ist;
        pca_pkg::pca_tgt_state_t   tst;
        logic [1:0]                rr;
        logic [3:0]                gnt;
        logic                      req0;
        logic [2:0]                wait_cnt;
        logic [31:0]               ad_o;
        logic                      ad_oe;
        logic [3:0]                cbe_o;
        logic                      cbe_oe;
        logic                      par_o, par_oe, par_pend;
        logic                      frame_o, irdy_o, ini_oe;
        logic                      trdy_o, stop_o, devsel_o, tgt_oe;
        logic                      perr_o, perr_oe, serr_o;
        logic                      t_write, t_special, chk;
        logic [35:0]               chk_v;
        logic                      busy, done, abort, perr_seen, serr_seen, inta;
        logic [31:0]               rdata, tdata;
        logic [3:0]                cmd;
        logic [4:0]                pin_oe;
    } st_t;
    st_t s_q, s_d;

    assign clk_p = clk_s & ~s_q.clk_l;
    assign bus.ad_o = s_q.ad_o;          assign bus.ad_oe = s_q.ad_oe;
    assign bus.cbe_o = s_q.cbe_o;        assign bus.cbe_oe = s_q.cbe_oe;
    assign bus.par_o = s_q.par_o;        assign bus.par_oe = s_q.par_oe;
    assign bus.frame_n_o = s_q.frame_o;  assign bus.frame_oe = s_q.ini_oe;
    assign bus.irdy_n_o = s_q.irdy_o;    assign bus.irdy_oe = s_q.ini_oe;
    assign bus.trdy_n_o = s_q.trdy_o;    assign bus.trdy_oe = s_q.tgt_oe;
    assign bus.stop_n_o = s_q.stop_o;    assign bus.stop_oe = s_q.tgt_oe;
    assign bus.devsel_n_o = s_q.devsel_o; assign bus.devsel_oe = s_q.tgt_oe;
    assign bus.perr_n_o = s_q.perr_o;    assign bus.perr_oe = s_q.perr_oe;
    assign bus.serr_n_o = 1'b0;          assign bus.serr_oe = s_q.serr_o;
    assign bus.inta_n_o = 1'b0;          assign bus.inta_oe = s_q.inta;
    // grants three..one, grant zero, request zero
    assign bus.gnt_n_o = ~s_q.gnt;
    assign bus.gnt_oe = s_q.pin_oe[4:1];
    assign bus.req_n_o = {3'h7, ~s_q.req0};
    assign bus.req_oe = {3'h0, s_q.pin_oe[0]};
    assign o_busy = s_q.busy;            assign o_done = s_q.done;
    assign o_abort = s_q.abort;          assign o_rdata = s_q.rdata;
    assign o_perr_seen = s_q.perr_seen;  assign o_serr_seen = s_q.serr_seen;
    assign o_tgt_data = s_q.tdata;

    always_comb begin
        logic [3:0] rq;
        logic       hit;
        logic       xfer;
        logic [1:0] k;
        rq = 4'h0;
        hit = 1'b0;
        xfer = 1'b0;
        k = 2'h0;
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.abort = 1'b0;
        s_d.clk_l = clk_s;
        s_d.inta = i_irq;
        // Registered so reset keeps arbitration pins released
        s_d.pin_oe = {3'h7, i_arb_en, ~i_arb_en};
        if (i_cmd_go && !s_q.busy) begin
            s_d.busy = 1'b1;
            s_d.cmd = i_cmd;
        end
        if (clk_p) begin
            if (!serr_n) s_d.serr_seen = 1'b1;
            s_d.serr_o = 1'b0;
            s_d.perr_oe = s_q.perr_oe & ~s_q.perr_o;
            s_d.perr_o = 1'b1;
            s_d.par_oe = s_q.ad_oe;
            s_d.par_o = ^{s_q.ad_o, s_q.cbe_o};
            if (s_q.chk) begin
                s_d.chk = 1'b0;
                if (par != ^s_q.chk_v) begin
                    if (s_q.t_special) s_d.serr_o = 1'b1;
                    else begin
                        s_d.perr_o = 1'b0;
                        s_d.perr_oe = 1'b1;
                        s_d.perr_seen = 1'b1;
                    end
                end
            end
            if (i_arb_en) begin
                rq = ~req_n;
                if (frame_n && irdy_n) begin
                    s_d.gnt = 4'h0;
                    for (int i = 1; i <= `PCA_N_REQ; i++) begin
                        k = 2'(s_q.rr + 2'(i));
                        if (rq[k] && s_d.gnt == 4'h0) begin
                            s_d.gnt[k] = 1'b1;
                            s_d.rr = k;
                        end
                    end
                end
            end else s_d.gnt = 4'h0;
            case (s_q.ist)
                pca_pkg::PCA_IDLE: begin
                    s_d.req0 = s_q.busy & ~i_arb_en;
                    if (s_q.busy && !i_arb_en && !gnt_n[0] && frame_n && irdy_n) begin
                        s_d.ist = pca_pkg::PCA_ADDR;
                        s_d.ad_o = i_addr;
                        s_d.ad_oe = 1'b1;
                        s_d.cbe_o = s_q.cmd;
                        s_d.cbe_oe = 1'b1;
                        s_d.frame_o = 1'b0;
                        s_d.irdy_o = 1'b1;
                        s_d.ini_oe = 1'b1;
                        s_d.req0 = 1'b0;
                        s_d.wait_cnt = 3'h0;
                    end
                end
                pca_pkg::PCA_ADDR: begin
                    s_d.ist = pca_pkg::PCA_DATA;
                    s_d.cbe_o = ~i_be;
                    s_d.frame_o = 1'b1;
                    s_d.irdy_o = 1'b0;
                    s_d.ad_o = i_wdata;
                    s_d.ad_oe = s_q.cmd[0];
                end
                pca_pkg::PCA_DATA: begin
                    s_d.wait_cnt = s_q.wait_cnt + 3'h1;
                    if (!trdy_n) begin
                        s_d.rdata = ad;
                        s_d.done = 1'b1;
                        s_d.ist = pca_pkg::PCA_TURN;
                    end else if (!stop_n) begin
                        s_d.abort = 1'b1;
                        s_d.ist = pca_pkg::PCA_TURN;
                    end else if (devsel_n && s_q.wait_cnt == `PCA_DEVSEL_WAIT) begin
                        s_d.abort = 1'b1;
                        s_d.ist = pca_pkg::PCA_TURN;
                    end
                    if (s_d.ist == pca_pkg::PCA_TURN) begin
                        s_d.irdy_o = 1'b1;
                        s_d.ad_oe = 1'b0;
                        s_d.cbe_oe = 1'b0;
                        s_d.busy = 1'b0;
                    end
                end
                pca_pkg::PCA_TURN: begin
                    s_d.ini_oe = 1'b0;
                    s_d.ist = pca_pkg::PCA_IDLE;
                end
                default: s_d.ist = pca_pkg::PCA_IDLE;
            endcase
            case (s_q.tst)
                pca_pkg::PCA_T_IDLE: begin
                    if (!frame_n && s_q.frame_o) begin
                        if (cbe == `PCA_CMD_CFG_RD || cbe == `PCA_CMD_CFG_WR) hit = ~idsel;
                        else if (cbe == `PCA_CMD_MEM_RD || cbe == `PCA_CMD_MEM_WR)
                            hit = (ad & `PCA_BAR_MASK) == BAR;
                        s_d.t_special = (cbe == `PCA_CMD_SPECIAL);
                        s_d.chk_v = {ad, cbe};
                        s_d.chk = 1'b1;
                        if (hit) begin
                            s_d.tst = pca_pkg::PCA_T_DATA;
                            s_d.t_write = cbe[0];
                            s_d.devsel_o = 1'b0;
                            s_d.trdy_o = 1'b0;
                            s_d.stop_o = frame_n;
                            s_d.tgt_oe = 1'b1;
                            if (!cbe[0]) begin
                                s_d.ad_o = s_q.tdata;
                                s_d.ad_oe = 1'b1;
                                s_d.cbe_o = 4'h0;
                            end
                        end
                    end
                end
                pca_pkg::PCA_T_DATA: begin
                    xfer = !irdy_n;
                    if (xfer) begin
                        if (s_q.t_write) begin
                            s_d.tdata = ad;
                            s_d.chk_v = {ad, cbe};
                            s_d.chk = 1'b1;
                        end
                        s_d.stop_o = frame_n;
                        if (frame_n) begin
                            s_d.tst = pca_pkg::PCA_T_TURN;
                            s_d.trdy_o = 1'b1;
                            s_d.devsel_o = 1'b1;
                            s_d.stop_o = 1'b1;
                            if (!s_q.t_write) s_d.ad_oe = 1'b0;
                        end
                    end
                end
                pca_pkg::PCA_T_TURN: begin
                    s_d.tgt_oe = 1'b0;
                    s_d.tst = pca_pkg::PCA_T_IDLE;
                end
                default: s_d.tst = pca_pkg::PCA_T_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s_q <= '0;
            s_q.frame_o <= 1'b1;
            s_q.irdy_o <= 1'b1;
            s_q.trdy_o <= 1'b1;
            s_q.stop_o <= 1'b1;
            s_q.devsel_o <= 1'b1;
            s_q.perr_o <= 1'b1;
            s_q.clk_l <= 1'b1;
        end else s_q <= s_d;
    end
endmodule

//--- rtl/pca_pkg.sv
package pca_pkg;
    typedef enum {PCA_IDLE, PCA_ADDR, PCA_DATA, PCA_TURN} pca_ini_state_t;
    typedef enum {PCA_T_IDLE, PCA_T_DATA, PCA_T_PERR, PCA_T_TURN} pca_tgt_state_t;
endpackage

//--- rtl/pca_sync.sv
`timescale 1ns/1ps
module pca_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_q;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            meta_q <= '1;
            o_q    <= '1;
        end else begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end
endmodule

//--- tb/pca_bus_asserts.sv
`timescale 1ns/1ps
module pca_bus_asserts (
    input wire logic        clk,
    input wire logic        i_sys_rst,
    input wire logic [31:0] ad_i,
    input wire logic [3:0]  cbe_i,
    input wire logic        par_i,
    input wire logic        par_oe,
    input wire logic        frame_n_i,
    input wire logic        irdy_n_i,
    input wire logic        trdy_n_i,
    input wire logic        devsel_n_i,
    input wire logic        idsel,
    input wire logic [3:0]  req_n_i,
    input wire logic [3:0]  gnt_n_o,
    input wire logic [3:0]  gnt_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (i_sys_rst);
    a_one_grant: assert property ($countones(~gnt_n_o & gnt_oe) <= 1)
        else $error("two grants at once");
    a_par_even: assert property (par_oe |-> par_i == ^{$past(ad_i), $past(cbe_i)})
        else $error("parity wrong");
    a_single_phase: assert property ($fell(frame_n_i) |=> frame_n_i && !irdy_n_i)
        else $error("frame not ended at data phase");
    a_xfer_end: assert property (!irdy_n_i && !trdy_n_i |=> irdy_n_i)
        else $error("initiator ready held after transfer");
    a_trdy_claim: assert property (!trdy_n_i |-> !devsel_n_i)
        else $error("target ready without claim");
    a_irdy_bound: assert property ($fell(irdy_n_i) |-> ##[1:8] irdy_n_i)
        else $error("data phase never ends");
    a_grant_req: assert property ($fell(gnt_n_o[1]) |-> $past(!req_n_i[1]))
        else $error("grant without request");
    a_cfg_idsel: assert property ($fell(frame_n_i) && cbe_i[3:1] == 3'h5 && !idsel
        |=> devsel_n_i [*4]) else $error("config claimed without select");
    c_claim: cover property (!irdy_n_i && !trdy_n_i);
    c_grant: cover property ($fell(gnt_n_o[1]));
    c_start: cover property ($fell(frame_n_i));
endmodule

//--- tb/pci_agent_with_arbiter_test.sv
`timescale 1ns/1ps
`include "pca_cfg.svh"
module pci_agent_with_arbiter_test;
    localparam logic [31:0] WD = 32'hA5C3_0F96;
    localparam logic [3:0] T_CMD [9] = '{`PCA_CMD_MEM_WR, `PCA_CMD_MEM_RD, `PCA_CMD_MEM_WR,
        `PCA_CMD_CFG_WR, `PCA_CMD_CFG_WR, `PCA_CMD_CFG_RD, `PCA_CMD_SPECIAL,
        `PCA_CMD_IO_WR, `PCA_CMD_IO_RD};
    localparam logic [8:0] T_SEL = 9'h030;
    localparam logic [8:0] T_AB  = 9'h1CC;
    logic        i_clk = 1'b0;
    logic        lclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        arb_en = 1'b1, irq = 1'b0, cmd_go = 1'b0, idsel = 1'b0;
    logic [3:0]  d_cmd = 4'h0, d_be = 4'hF, a_cmd = 4'h0;
    logic [31:0] d_addr = 32'h0, d_wdata = 32'h0, a_addr = 32'h0, a_wdata = 32'h0;
    logic        go = 1'b0, a_gnt0 = 1'b1;
    logic        d_busy, d_done, d_abort, d_perr, d_serr, a_req0, a_done, a_abort;
    logic [31:0] d_rdata, d_tgt, a_rdata;
    int          n_fail = 0, n_checks = 0;
    pca_bus_if bus_d ();
    pca_bus_if bus_a ();
    always #4 i_clk = ~i_clk;
    // Link clock free of the system clock phase
    initial begin
        #3;
        forever #32 lclk = ~lclk;
    end
    function automatic logic [31:0] rv(input logic ed, input logic [31:0] vd,
                                       input logic ea, input logic [31:0] va);
        return ed ? vd : (ea ? va : 32'hFFFF_FFFF);
    endfunction
    // Pull-ups win where nobody drives
    always_comb begin
        bus_d.clk = lclk;
        bus_a.clk = lclk;
        bus_d.idsel = idsel;
        bus_d.ad_i = rv(bus_d.ad_oe, bus_d.ad_o, bus_a.ad_oe, bus_a.ad_o);
        bus_a.ad_i = bus_d.ad_i;
        bus_d.cbe_i = 4'(rv(bus_d.cbe_oe, 32'(bus_d.cbe_o), bus_a.cbe_oe, 32'(bus_a.cbe_o)));
        bus_a.cbe_i = bus_d.cbe_i;
        bus_d.par_i = 1'(rv(bus_d.par_oe, 32'(bus_d.par_o), bus_a.par_oe, 32'(bus_a.par_o)));
        bus_a.par_i = bus_d.par_i;
        bus_d.frame_n_i = 1'(rv(bus_d.frame_oe, 32'(bus_d.frame_n_o),
                                bus_a.frame_oe, 32'(bus_a.frame_n_o)));
        bus_a.frame_n_i = bus_d.frame_n_i;
        bus_d.irdy_n_i = 1'(rv(bus_d.irdy_oe, 32'(bus_d.irdy_n_o),
                               bus_a.irdy_oe, 32'(bus_a.irdy_n_o)));
        bus_a.irdy_n_i = bus_d.irdy_n_i;
        bus_d.trdy_n_i = 1'(rv(bus_d.trdy_oe, 32'(bus_d.trdy_n_o),
                               bus_a.trdy_oe, 32'(bus_a.trdy_n_o)));
        bus_a.trdy_n_i = bus_d.trdy_n_i;
        bus_d.stop_n_i = 1'(rv(bus_d.stop_oe, 32'(bus_d.stop_n_o),
                               bus_a.stop_oe, 32'(bus_a.stop_n_o)));
        bus_a.stop_n_i = bus_d.stop_n_i;
        bus_d.devsel_n_i = 1'(rv(bus_d.devsel_oe, 32'(bus_d.devsel_n_o),
                                 bus_a.devsel_oe, 32'(bus_a.devsel_n_o)));
        bus_a.devsel_n_i = bus_d.devsel_n_i;
        bus_d.perr_n_i = 1'(rv(bus_d.perr_oe, 32'(bus_d.perr_n_o),
                               bus_a.perr_oe, 32'(bus_a.perr_n_o)));
        bus_a.perr_n_i = bus_d.perr_n_i;
        bus_d.serr_n_i = ~(bus_d.serr_oe | bus_a.serr_oe);
        bus_a.serr_n_i = bus_d.serr_n_i;
        for (int k = 0; k < 4; k++) begin
            bus_d.req_n_i[k] = bus_a.req_oe[k] ? bus_a.req_n_o[k] : 1'b1;
            bus_a.gnt_n_i[k] = bus_d.gnt_oe[k] ? bus_d.gnt_n_o[k] : 1'b1;
            bus_d.gnt_n_i[k] = 1'b1;
        end
        // Bench arbiter grants at once when the device asks
        if (!arb_en)
            bus_d.gnt_n_i[0] = bus_d.req_n_o[0];
    end
    pca_device i_pca_device (.i_clk(i_clk), .i_sys_rst(sys_rst), .i_arb_en(arb_en),
        .i_irq(irq), .i_cmd_go(cmd_go), .i_cmd(d_cmd), .i_addr(d_addr), .i_wdata(d_wdata),
        .i_be(d_be), .o_busy(d_busy), .o_done(d_done), .o_abort(d_abort),
        .o_rdata(d_rdata), .o_perr_seen(d_perr), .o_serr_seen(d_serr),
        .o_tgt_data(d_tgt), .bus(bus_d));
    pca_agent i_pca_agent (.i_clk(i_clk), .i_sys_rst(sys_rst), .i_go(go), .i_cmd(a_cmd),
        .i_addr(a_addr), .i_wdata(a_wdata), .i_gnt0(a_gnt0), .o_req0(a_req0),
        .o_done(a_done), .o_abort(a_abort), .o_rdata(a_rdata), .bus(bus_a));
    pca_bus_asserts i_pca_bus_asserts (.clk(lclk), .i_sys_rst(sys_rst),
        .ad_i(bus_d.ad_i), .cbe_i(bus_d.cbe_i), .par_i(bus_d.par_i),
        .par_oe(bus_d.par_oe | bus_a.par_oe), .frame_n_i(bus_d.frame_n_i),
        .irdy_n_i(bus_d.irdy_n_i), .trdy_n_i(bus_d.trdy_n_i),
        .devsel_n_i(bus_d.devsel_n_i), .idsel(idsel), .req_n_i(bus_d.req_n_i),
        .gnt_n_o(bus_d.gnt_n_o), .gnt_oe(bus_d.gnt_oe));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wait_end(input logic dev, output logic ab);
        ab = 1'bx;
        for (int k = 0; k < 600; k++) begin
            @(posedge i_clk);
            #1;
            if (dev ? (d_done | d_abort) : (a_done | a_abort)) begin
                ab = dev ? d_abort : a_abort;
                return;
            end
        end
        n_fail++;
        $display("unexpected end: transfer never completed");
    endtask
    task automatic test_reset;
        repeat (6) @(posedge i_clk);
        #1;
        check("dev oe", 32'({bus_d.ad_oe, bus_d.cbe_oe, bus_d.par_oe, bus_d.frame_oe,
            bus_d.irdy_oe, bus_d.trdy_oe, bus_d.stop_oe, bus_d.devsel_oe, bus_d.perr_oe,
            bus_d.serr_oe, bus_d.req_oe, bus_d.gnt_oe, bus_d.inta_oe}), 32'h0);
        repeat (6) @(posedge i_clk);
        #1 sys_rst = 1'b0;
        repeat (8) @(posedge i_clk);
        #1;
    endtask
    task automatic test_txns;
        logic ab;
        check("arb oe", 32'({bus_d.gnt_oe, bus_d.req_oe[0]}), 32'h1E);
        for (int i = 0; i < 9; i++) begin
            idsel = T_SEL[i];
            a_cmd = T_CMD[i];
            a_addr = (i == 2) ? 32'h7FFF_0010 : (i < 2 ? 32'h8000_0010 : 32'h0);
            a_wdata = WD;
            go = 1'b1;
            @(posedge i_clk);
            #1 go = 1'b0;
            @(posedge i_clk);
            #1 check("agent req", 32'(a_req0), 32'h1);
            wait_end(1'b0, ab);
            check("abort", 32'(ab), 32'(T_AB[i]));
            if (i == 0)
                check("target data", d_tgt, WD);
            if (i == 1)
                check("read data", a_rdata, WD);
            repeat (40) @(posedge i_clk);
            #1;
        end
        check("error flags", 32'({d_perr, d_serr}), 32'h0);
    endtask
    task automatic test_arb_off;
        logic ab;
        arb_en = 1'b0;
        a_gnt0 = 1'b0;
        repeat (8) @(posedge i_clk);
        #1;
        check("own req oe", 32'({bus_d.req_oe[0], bus_d.gnt_oe[0]}), 32'h2);
        d_cmd = `PCA_CMD_MEM_WR;
        d_addr = 32'h4000_0000;
        d_wdata = WD;
        cmd_go = 1'b1;
        @(posedge i_clk);
        #1 cmd_go = 1'b0;
        check("own busy", 32'(d_busy), 32'h1);
        wait_end(1'b1, ab);
        check("own abort", 32'(ab), 32'h1);
        check("own idle", 32'(d_busy), 32'h0);
        arb_en = 1'b1;
        a_gnt0 = 1'b1;
    endtask
    task automatic test_irq;
        irq = 1'b1;
        repeat (4) @(posedge i_clk);
        #1;
        check("irq on", 32'({bus_d.inta_oe, bus_d.inta_n_o}), 32'h2);
        irq = 1'b0;
        repeat (4) @(posedge i_clk);
        #1;
        check("irq off", 32'(bus_d.inta_oe), 32'h0);
    endtask
    initial begin
        test_reset();
        test_txns();
        test_arb_off();
        test_irq();
        finish_test();
    end
    initial begin
        #100000;
        n_fail++;
        finish_test();
    end
endmodule
